// >>> core/uwbc_top.v
// Implementation choice: register access over Wishbone.
`default_nettype none
`include "uwbc_consts.vh"
// Function
// - Sleep suppresses every receiver status flag
// - New message or software write clears sleep
// - Idle wakeup after one frame of ones
// - Address character (MSB one) wakes sleeper
// - Short idle counts after start, long after stop
// - 13-bit modulus prescaler from crystal clock
// - Baud equals clock over 32 over divisor
// - Divisor high in bits 4..0, bit5 zero
// - Divisor writable any time, takes effect
// - Test bits writable in test mode only
// - Loop feeds transmitter to receiver, pin high
// - Open-drain pins when wired-OR bit set
// - Word bit selects eight or nine data bits
// - Wake bit selects idle or address wakeup
// - Parity enable, even or odd type
// - Transmit empty, complete, idle interrupt enables
// - Receive enable covers full and overrun
// - Start zero, LSB first, stop one
// - Idle flag once after message activity
module uwbc_top (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [31:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  output wire wb_ack_out,
  // Device mode
  input wire test_mode_in,
  // Serial pins
  input wire rxd_in,
  output wire txd_out,
  output wire txd_oe_out,
  // Interrupt request
  output wire irq_out
);

  function parity9;
    input [8:0] bits;
    input word9;
    input odd;
    begin
      parity9 = ^(bits & (word9 ? 9'h0FF : 9'h07F)) ^ odd;
    end
  endfunction

  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  reg [7:0] ctl1_q;
  reg [7:0] ctl2_q;
  reg [12:0] div_q;
  reg [1:0] test_q;
  reg ack_q;
  reg [31:0] rdat_q;
  reg tx_empty_flag_q, tc_q, rx_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q;
  reg armed_q;
  reg [8:0] tx_buf_q;
  reg [8:0] rx_buf_q;
  reg sync1_q, sync2_q;

  wire req = wb_cyc_in & wb_stb_in & ~ack_q;
  wire wr = req & wb_we_in & wb_sel_in[0];
  wire rd = req & ~wb_we_in;
  wire [6:0] idx = wb_adr_in[8:2];
  wire [7:0] wb8 = wb_dat_in[7:0];
  wire wr_bh = wr & (idx == `UWBC_IDX_BAUD_HIGH);
  wire wr_bl = wr & (idx == `UWBC_IDX_BAUD_LOW);
  wire wr_c1 = wr & (idx == `UWBC_IDX_CTRL_ONE);
  wire wr_c2 = wr & (idx == `UWBC_IDX_CTRL_TWO);
  wire wr_dl = wr & (idx == `UWBC_IDX_DATA_LOW);
  wire wr_dh = wr & (idx == `UWBC_IDX_DATA_HIGH);
  wire rd_s1 = rd & (idx == `UWBC_IDX_STATUS_ONE);
  wire rd_dl = rd & (idx == `UWBC_IDX_DATA_LOW);

  wire loop_en = ctl1_q[`UWBC_C1_LOOP];
  wire od_en = ctl1_q[`UWBC_C1_ODRAIN];
  wire word9 = ctl1_q[`UWBC_C1_WORD9];
  wire wake_addr = ctl1_q[`UWBC_C1_WAKE];
  wire ilt_long = ctl1_q[`UWBC_C1_ILT];
  wire par_en = ctl1_q[`UWBC_C1_PE];
  wire par_odd = ctl1_q[`UWBC_C1_PT];
  wire te = ctl2_q[`UWBC_C2_TE];
  wire re = ctl2_q[`UWBC_C2_RE];
  wire sleep = ctl2_q[`UWBC_C2_RWU];

  // ---------------------------------------------
  // Baud prescaler
  // ---------------------------------------------
  reg [12:0] pre_q;
  // Zero divisor holds the generator still
  wire tick = (div_q != 13'h0000) && (pre_q >= div_q - 13'h0001);
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      pre_q <= 13'h0000;
    end else if (tick || div_q == 13'h0000) begin
      pre_q <= 13'h0000;
    end else begin
      // Compare with >= so a smaller new divisor applies at once
      pre_q <= pre_q + 13'h0001;
    end
  end

  // ---------------------------------------------
  // Transmitter
  // ---------------------------------------------
  reg tx_busy_q;
  reg [10:0] tx_sh_q;
  reg [3:0] tx_bits_q;
  reg [4:0] tx_ph_q;
  reg tx_line_q;
  wire [3:0] frame_bits = word9 ? 4'hB : 4'hA;
  wire [8:0] tx_word = par_en ?
    (word9 ? {parity9(tx_buf_q, 1'b1, par_odd), tx_buf_q[7:0]}
           : {1'b0, parity9(tx_buf_q, 1'b0, par_odd), tx_buf_q[6:0]}) : tx_buf_q;
  wire tx_load = ~tx_busy_q & ~tx_empty_flag_q & te;
  wire tx_done = tx_busy_q & tick & (tx_ph_q == `UWBC_TICKS_PER_BIT)
                 & (tx_bits_q == 4'h1);
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_ph_q <= 5'h00;
      tx_line_q <= 1'b1;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      // Start zero, word LSB first, stop one
      tx_sh_q <= word9 ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
      tx_bits_q <= frame_bits;
      tx_ph_q <= 5'h00;
      tx_line_q <= 1'b1;
    end else if (tx_busy_q && tick) begin
      tx_ph_q <= tx_ph_q + 5'h01;
      if (tx_ph_q == 5'h00) begin
        tx_line_q <= tx_sh_q[0];
      end
      if (tx_ph_q == `UWBC_TICKS_PER_BIT) begin
        tx_sh_q <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        if (tx_bits_q == 4'h1) begin
          tx_busy_q <= 1'b0;
        end
      end
    end
  end

  // Loop: pin parks high, receiver hears the shifter
  wire tx_bit = loop_en ? 1'b1 : tx_line_q;
  assign txd_out = od_en ? 1'b0 : tx_bit;
  assign txd_oe_out = te & (~od_en | ~tx_bit);

  // ---------------------------------------------
  // Receiver
  // ---------------------------------------------
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= rxd_in;
      sync2_q <= sync1_q;
    end
  end
  // Loop needs both ends enabled
  wire rx_src = loop_en ? (te ? tx_line_q : 1'b1) : sync2_q;
  wire rx_line = re ? rx_src : 1'b1;

  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  reg [1:0] rx_st_q;
  reg [4:0] rx_ph_q;
  reg [3:0] rx_cnt_q;
  reg [8:0] rx_sh_q;
  reg [2:0] smp_q;
  reg noise_q;
  reg rx_end_q;
  reg [8:0] rx_word_q;
  reg rx_ferr_q, rx_noise_q;
  wire [2:0] smp_now = {smp_q[1:0], rx_line};
  wire bit_val = maj3(smp_now);
  wire bit_noisy = ~(&smp_now) & (|smp_now);
  wire at_mid = tick & (rx_ph_q == `UWBC_SAMPLE_C);
  wire [3:0] data_bits = word9 ? 4'h9 : 4'h8;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 5'h00;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      smp_q <= 3'h7;
      noise_q <= 1'b0;
      rx_end_q <= 1'b0;
      rx_word_q <= 9'h000;
      rx_ferr_q <= 1'b0;
      rx_noise_q <= 1'b0;
    end else begin
      rx_end_q <= 1'b0;
      if (tick) begin
        rx_ph_q <= rx_ph_q + 5'h01;
        if (rx_ph_q == `UWBC_SAMPLE_A || rx_ph_q == `UWBC_SAMPLE_B) begin
          smp_q <= smp_now;
        end
      end
      case (rx_st_q)
        RX_IDLE: begin
          if (tick && !rx_line) begin
            rx_st_q <= RX_START;
            rx_ph_q <= 5'h01;
            noise_q <= 1'b0;
          end
        end
        RX_START: begin
          if (at_mid) begin
            // False start bit returns to idle
            rx_st_q <= bit_val ? RX_IDLE : RX_DATA;
            noise_q <= bit_noisy;
            rx_cnt_q <= 4'h0;
          end
        end
        RX_DATA: begin
          if (at_mid) begin
            noise_q <= noise_q | bit_noisy;
            rx_sh_q <= word9 ? {bit_val, rx_sh_q[8:1]} : {1'b0, bit_val, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == data_bits - 4'h1) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (at_mid) begin
            rx_st_q <= RX_IDLE;
            rx_end_q <= 1'b1;
            rx_word_q <= rx_sh_q;
            rx_ferr_q <= ~bit_val;
            rx_noise_q <= noise_q | bit_noisy;
          end
        end
        default: begin
          rx_st_q <= RX_IDLE;
        end
      endcase
    end
  end
  wire rx_busy = (rx_st_q != RX_IDLE);
  wire rx_msb = word9 ? rx_word_q[8] : rx_word_q[7];
  wire rx_par_bad = par_en & (parity9(rx_word_q, word9, par_odd) ^ rx_msb);
  wire addr_wake = sleep & wake_addr & rx_end_q & rx_msb;

  // ---------------------------------------------
  // Idle line detection
  // ---------------------------------------------
  reg [8:0] ones_q;
  reg active_q;
  wire [8:0] idle_need = {frame_bits, 5'h00};
  // Short mode keeps counting through trailing ones of a frame
  wire ones_clr = ~rx_line | (ilt_long & rx_busy);
  wire idle_hit = tick & ~ones_clr & (ones_q == idle_need - 9'h001);
  wire idle_wake = sleep & ~wake_addr & idle_hit;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ones_q <= 9'h000;
      active_q <= 1'b0;
    end else begin
      if (ones_clr) begin
        ones_q <= 9'h000;
      // Saturate at the limit, so a word-size change cannot wrap the count
      end else if (tick && ones_q < idle_need) begin
        ones_q <= ones_q + 9'h001;
      end
      // Armed by traffic, spent by the next idle detection, even one not reported while asleep
      if (rx_busy) begin
        active_q <= 1'b1;
      end else if (idle_hit) begin
        active_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Status flags
  // ---------------------------------------------
  wire rx_ok = rx_end_q & (~sleep | addr_wake);
  wire rx_clr = rd_dl & armed_q;
  wire load_rdr = rx_ok & ~rx_full_flag_q & ~fe_q;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      tx_empty_flag_q <= 1'b1;
      tc_q <= 1'b1;
      rx_full_flag_q <= 1'b0;
      idle_q <= 1'b0;
      or_q <= 1'b0;
      nf_q <= 1'b0;
      fe_q <= 1'b0;
      pf_q <= 1'b0;
      armed_q <= 1'b0;
      tx_buf_q <= 9'h000;
      rx_buf_q <= 9'h000;
    end else begin
      if (rd_s1) begin
        armed_q <= 1'b1;
      end else if (rd_dl || wr_dl) begin
        armed_q <= 1'b0;
      end
      if (wr_dl) begin
        tx_buf_q[7:0] <= wb8;
      end
      if (wr_dh) begin
        tx_buf_q[8] <= wb8[0];
      end
      // Events win over clears in the same cycle
      if (tx_load) begin
        tx_empty_flag_q <= 1'b1;
      end else if (wr_dl) begin
        tx_empty_flag_q <= 1'b0;
      end
      if (tx_done) begin
        tc_q <= 1'b1;
      end else if (wr_dl) begin
        tc_q <= 1'b0;
      end
      if (load_rdr) begin
        rx_full_flag_q <= 1'b1;
        rx_buf_q <= rx_word_q;
        nf_q <= rx_noise_q;
        fe_q <= rx_ferr_q;
        pf_q <= rx_par_bad;
      end else if (rx_clr) begin
        rx_full_flag_q <= 1'b0;
        nf_q <= 1'b0;
        fe_q <= 1'b0;
        pf_q <= 1'b0;
      end
      if (rx_ok && (rx_full_flag_q || fe_q)) begin
        or_q <= 1'b1;
      end else if (rx_clr) begin
        or_q <= 1'b0;
      end
      if (idle_hit && active_q && !sleep) begin
        idle_q <= 1'b1;
      end else if (rx_clr) begin
        idle_q <= 1'b0;
      end
    end
  end

  // Receiver activity hidden while asleep
  wire rx_active_flag = rx_busy & ~sleep;

  assign irq_out = (tx_empty_flag_q & ctl2_q[`UWBC_C2_TIE]) | (tc_q & ctl2_q[`UWBC_C2_TX_COMPLETE_IRQ_ENABLE])
                 | (idle_q & ctl2_q[`UWBC_C2_IDLE_IRQ_ENABLE])
                 | ((rx_full_flag_q | or_q) & ctl2_q[`UWBC_C2_RIE]);

  // ---------------------------------------------
  // Control registers
  // ---------------------------------------------
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctl1_q <= `UWBC_RST_BYTE;
      ctl2_q <= `UWBC_RST_BYTE;
      div_q <= `UWBC_RST_DIV;
      test_q <= 2'b00;
    end else begin
      if (wr_c1) begin
        ctl1_q <= {wb8[7:6], 1'b0, wb8[4:0]};
      end
      if (wr_c2) begin
        ctl2_q <= wb8;
      end else if (idle_wake || addr_wake) begin
        ctl2_q[`UWBC_C2_RWU] <= 1'b0;
      end
      if (wr_bh) begin
        div_q[12:8] <= wb8[4:0];
        if (test_mode_in) begin
          test_q <= wb8[7:6];
        end
      end
      if (wr_bl) begin
        div_q[7:0] <= wb8;
      end
    end
  end

  // ---------------------------------------------
  // Bus read path
  // ---------------------------------------------
  reg [7:0] rmux;
  always @* begin
    case (idx)
      `UWBC_IDX_BAUD_HIGH: rmux = {test_q, 1'b0, div_q[12:8]};
      `UWBC_IDX_BAUD_LOW: rmux = div_q[7:0];
      `UWBC_IDX_CTRL_ONE: rmux = ctl1_q;
      `UWBC_IDX_CTRL_TWO: rmux = ctl2_q;
      `UWBC_IDX_STATUS_ONE: rmux = {tx_empty_flag_q, tc_q, rx_full_flag_q, idle_q, or_q, nf_q, fe_q, pf_q};
      `UWBC_IDX_STATUS_TWO: rmux = {7'h00, rx_active_flag};
      `UWBC_IDX_DATA_LOW: rmux = rx_buf_q[7:0];
      `UWBC_IDX_DATA_HIGH: rmux = {7'h00, rx_buf_q[8]};
      default: rmux = 8'h00;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      rdat_q <= rd ? {24'h000000, rmux} : 32'h00000000;
    end
  end
  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

endmodule
`default_nettype wire

// >>> inc/uwbc_consts.vh
`ifndef UWBC_CONSTS_VH
`define UWBC_CONSTS_VH
// ---------------------------------------------
// Register indices (byte address = 4 * index)
// ---------------------------------------------
`define UWBC_IDX_BAUD_HIGH 7'h70
`define UWBC_IDX_BAUD_LOW 7'h71
`define UWBC_IDX_CTRL_ONE 7'h72
`define UWBC_IDX_CTRL_TWO 7'h73
`define UWBC_IDX_STATUS_ONE 7'h74
`define UWBC_IDX_STATUS_TWO 7'h75
`define UWBC_IDX_DATA_LOW 7'h76
`define UWBC_IDX_DATA_HIGH 7'h77
// ---------------------------------------------
// Control one fields
// ---------------------------------------------
`define UWBC_C1_LOOP 7
`define UWBC_C1_ODRAIN 6
`define UWBC_C1_WORD9 4
`define UWBC_C1_WAKE 3
`define UWBC_C1_ILT 2
`define UWBC_C1_PE 1
`define UWBC_C1_PT 0
// ---------------------------------------------
// Control two fields
// ---------------------------------------------
`define UWBC_C2_TIE 7
`define UWBC_C2_TX_COMPLETE_IRQ_ENABLE 6
`define UWBC_C2_RIE 5
`define UWBC_C2_IDLE_IRQ_ENABLE 4
`define UWBC_C2_TE 3
`define UWBC_C2_RE 2
`define UWBC_C2_RWU 1
`define UWBC_C2_SBK 0
// ---------------------------------------------
// Reset values and timing
// ---------------------------------------------
`define UWBC_RST_BYTE 8'h00
`define UWBC_RST_DIV 13'h0000
`define UWBC_TICKS_PER_BIT 5'h1F
`define UWBC_SAMPLE_A 5'h0E
`define UWBC_SAMPLE_B 5'h0F
`define UWBC_SAMPLE_C 5'h10
`endif

// >>> test/uwbc_checker.sv
`default_nettype none
module uwbc_checker (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // Bus
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [31:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire [31:0] wb_dat_out,
  input wire wb_ack_out,
  // Pins
  input wire test_mode_in,
  input wire txd_out,
  input wire txd_oe_out,
  input wire irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic req;
  logic rd;
  logic [6:0] idx;
  logic [7:0] c1_q, c2_q;
  logic tw_q;
  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign rd = req & ~wb_we_in;
  assign idx = wb_adr_in[8:2];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------
  // Shadow of control writes
  // ----------------------------
  // Sleep bit self-clears in the design, so c2_q bit 1 is never used
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      tw_q <= 1'b0;
    end else if (req & wb_we_in & wb_sel_in[0]) begin
      if (idx == 7'h72) c1_q <= wb_dat_in[7:0] & 8'hDF;
      if (idx == 7'h73) c2_q <= wb_dat_in[7:0];
      if (idx == 7'h70 && test_mode_in) tw_q <= 1'b1;
    end
  end
  AST_ACK_NEXT: assert property (req |=> wb_ack_out)
    else $error("ack late");
  AST_ACK_ONE: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0 ##1 !wb_ack_out)
    else $error("ack too long");
  AST_HIGH_BIT5: assert property (rd && idx == 7'h70 |=> !wb_dat_out[5])
    else $error("bit5 set");
  AST_TEST_BITS: assert property (rd && idx == 7'h70 && !tw_q |=> wb_dat_out[7:6] == 2'b00)
    else $error("test bits set");
  AST_CTRL_READ: assert property (rd && idx == 7'h72 |=> wb_dat_out[7:0] == $past(c1_q))
    else $error("control one readback");
  AST_LOOP_HIGH: assert property (c1_q[7] && c2_q[3] && !c1_q[6] |-> txd_out)
    else $error("loop pin low");
  AST_ODRAIN: assert property (c1_q[6] |-> !txd_out)
    else $error("open drain drives high");
  AST_IRQ_OFF: assert property (c2_q[7:4] == 4'h0 |-> !irq_out)
    else $error("irq without enable");
endmodule
bind uwbc_top uwbc_checker i_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .test_mode_in(test_mode_in), .txd_out(txd_out),
  .txd_oe_out(txd_oe_out), .irq_out(irq_out)
);
`default_nettype wire

// >>> test/uwbc_node.sv
`default_nettype none
module uwbc_node (
  // Clock
  input wire logic clk_in,
  // Device transmit pin
  input wire logic txd_in,
  input wire logic oe_in,
  // Device receive pin
  output logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic line;
  // Pull-up holds the released wire high
  assign line = oe_in ? txd_in : 1'b1;
  initial rxd_out = 1'b1;
  // Stop then return: no gap added inside a message
  task automatic send(input logic [8:0] d, input int nb, input int bt);
    rxd_out <= 1'b0;
    repeat (bt) @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      rxd_out <= d[i];
      repeat (bt) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
    repeat (bt) @(posedge clk_in);
  endtask
  task automatic recv(input int nb, input int bt, output logic [10:0] f);
    f = 11'h7FF;
    // Sample on the falling edge, where the pin has settled
    while (line !== 1'b0)
      @(negedge clk_in);
    repeat (bt / 2) @(negedge clk_in);
    for (int i = 0; i < nb + 2; i++) begin
      f[i] = line;
      repeat (bt) @(negedge clk_in);
    end
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> test/uwbc_wakeup_baud_control_test.sv
`default_nettype none
module uwbc_wakeup_baud_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cyc, stb, we, tm, ack, txd, oe, irq, rxd;
  logic [31:0] adr, dat, dat_r;
  logic [7:0] r, c1;
  logic [8:0] w, e;
  logic [10:0] f;
  logic [10:0] exq[$];
  logic [7:0] cfg[4] = '{8'h00, 8'h50, 8'h03, 8'h12};
  int seed, n_fail, total_checks, dv, bt, nb;
  uwbc_top i_dut (
    .ref_clk_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dat),
    .wb_dat_out(dat_r), .wb_ack_out(ack), .test_mode_in(tm), .rxd_in(rxd),
    .txd_out(txd), .txd_oe_out(oe), .irq_out(irq)
  );
  uwbc_node i_node (.clk_in(clk), .txd_in(txd), .oe_in(oe), .rxd_out(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [10:0] x, input logic [10:0] y);
    total_checks++;
    if (x !== y) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", s, x, y);
    end
  endtask
  task automatic wb(input logic w_en, input logic [6:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= {23'h0, a, 2'h0};
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    r = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), x, r & m);
  endtask
  initial begin
    {rst, cyc, stb, we, tm} = 5'h10;
    adr = 32'h0;
    dat = 32'h0;
    seed = 32'h7E8A0359;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(7'h70, 8'h00);
    rdc(7'h73, 8'h00);
    rdc(7'h10, 8'h00);
    rdc(7'h74, 8'hC0);
    wb(1'b1, 7'h73, 8'h80);
    chk("irq", 1'b1, irq);
    wb(1'b1, 7'h70, 8'hFF);
    rdc(7'h70, 8'h1F);
    tm <= 1'b1;
    wb(1'b1, 7'h70, 8'hC0);
    rdc(7'h70, 8'hC0);
    wb(1'b1, 7'h70, 8'h00);
    tm <= 1'b0;
    // Divisor changes between frames to prove it takes effect
    for (int k = 0; k < 4; k++) begin
      dv = 1 + k % 2;
      bt = 32 * dv;
      c1 = cfg[k];
      nb = c1[4] ? 9 : 8;
      w = 9'($random(seed));
      e = w & ~(9'h1FF << nb);
      if (c1[1])
        e[nb - 1] = ^(e & ~(9'h1FF << (nb - 1))) ^ c1[0];
      exq.push_back((11'h7FF << (nb + 1)) | {1'b0, e, 1'b0});
      wb(1'b1, 7'h71, 8'(dv));
      wb(1'b1, 7'h72, c1);
      wb(1'b1, 7'h77, {7'h0, w[8]});
      wb(1'b1, 7'h73, 8'h08);
      wb(1'b1, 7'h76, w[7:0]);
      i_node.recv(nb, bt, f);
      chk("tx frame", exq.pop_front(), f);
    end
    rdc(7'h72, 8'h12);
    wb(1'b1, 7'h71, 8'h00);
    wb(1'b1, 7'h72, 8'h00);
    wb(1'b1, 7'h76, 8'h5A);
    repeat (200) @(posedge clk);
    rdc(7'h74, 8'h00, 8'h40);
    chk("pin", 1'b1, i_node.line);
    wb(1'b1, 7'h71, 8'h02);
    wb(1'b1, 7'h73, 8'h24);
    w = 9'($random(seed)) & 9'h07F;
    i_node.send(w, 8, bt);
    chk("irq", 1'b1, irq);
    rdc(7'h74, 8'hE0);
    rdc(7'h76, w[7:0]);
    chk("irq", 1'b0, irq);
    repeat (11 * bt) @(posedge clk);
    rdc(7'h74, 8'hD0);
    rdc(7'h76, w[7:0]);
    repeat (11 * bt) @(posedge clk);
    rdc(7'h74, 8'hC0);
    // Even parity: bad parity char, then a good one back to back overruns
    wb(1'b1, 7'h72, 8'h02);
    i_node.send(9'h001, 8, bt);
    i_node.send(9'h081, 8, bt);
    rdc(7'h74, 8'hE9);
    rdc(7'h76, 8'h01);
    wb(1'b1, 7'h72, 8'h00);
    wb(1'b1, 7'h73, 8'h26);
    i_node.send(9'h015, 8, bt);
    rdc(7'h74, 8'hC0);
    repeat (11 * bt) @(posedge clk);
    rdc(7'h73, 8'h24);
    wb(1'b0, 7'h74, 8'h00);
    wb(1'b0, 7'h76, 8'h00);
    wb(1'b1, 7'h72, 8'h08);
    wb(1'b1, 7'h73, 8'h26);
    i_node.send(9'h015, 8, bt);
    rdc(7'h74, 8'hC0);
    chk("irq", 1'b0, irq);
    i_node.send(9'h095, 8, bt);
    rdc(7'h73, 8'h24);
    rdc(7'h74, 8'hE0);
    rdc(7'h76, 8'h95);
    wb(1'b1, 7'h72, 8'h80);
    wb(1'b1, 7'h73, 8'h0C);
    w = 9'($random(seed));
    wb(1'b1, 7'h76, w[7:0]);
    repeat (12 * bt) @(posedge clk);
    rdc(7'h76, w[7:0]);
    final_report;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    final_report;
  end
endmodule
`default_nettype wire
